/* verilog/feoc_top.sv */
// Notes on behaviour
// - compare each option byte with its complement
// - mismatch raises option verify error flag
// - secded over each 64-bit double-word
// - corrected error sets flag, raises interrupt
// - uncorrectable error sets flag, raises nmi
// - capture failing location and bank
// - check ecc on every flash read
// - block protected accesses, fault on reads
`default_nettype none
module feoc_top
(
    input  wire  logic                          I_CLK_SYS,
    input  wire  logic                          I_RST_N,
    input  wire  logic                          I_CLK_EN,
    input  wire  feoc_pkg::feoc_apb_req_s       I_APB,
    output logic [31:0]                         O_PRDATA,
    output logic                                O_PREADY,
    output logic                                O_PSLVERR,
    input  wire  logic                          I_OPT_VALID,
    input  wire  feoc_pkg::feoc_opt_s           I_OPT,
    input  wire  logic                          I_ACC_REQ,
    input  wire  feoc_pkg::feoc_acc_s           I_ACC,
    output logic                                O_ACC_READY,
    output logic                                O_ACC_DONE,
    output logic                                O_ACC_BLOCKED,
    output logic                                O_FAULT_EXC,
    output logic [feoc_pkg::DATA_W-1:0]         O_RD_DATA,
    output logic                                O_FL_REQ,
    output feoc_pkg::feoc_acc_s                 O_FL_CMD,
    input  wire  logic                          I_FL_VALID,
    input  wire  feoc_pkg::feoc_fl_word_s       I_FL_WORD,
    output logic                                O_IRQ,
    output logic                                O_NMI,
    output logic                                O_OPT_VERIFY_ERROR,
    output logic                                O_OPT_LOADED
);
    import feoc_pkg::*;

    // sequencer
    feoc_state_e       state_q; // access sequencer state
    feoc_acc_s         acc_q, fl_cmd_q; // access served, command held
    logic              ready_q; // new access may be taken
    logic              done_q, blocked_q, fault_q; // completion pulses
    logic [DATA_W-1:0] rd_data_q; // returned read data
    logic              fl_req_q; // request pulse to the array
    // option load
    logic              opt_err_q, opt_done_q; // option_verify_error, loaded
    // software registers
    logic [LOC_W-1:0]  ecc_loc_q; // failing double-word location
    logic              ecc_bank_q; // failing_bank_select
    logic              ecc_corr_q, ecc_det_q; // ecc_corrected_flag, ecc_detected_flag
    logic [INT_W-1:0]  int_stat_q; // sticky events, read clears
    logic [INT_W-1:0]  int_mask_q; // interrupt enables
    logic [1:0]        prot_q; // read/write protection enables
    logic [LOC_W-1:0]  wrp_start_q, wrp_end_q; // protected window
    logic              irq_q, nmi_q; // interrupt lines
    // apb slave
    logic              pready_q, pslverr_q; // handshake
    logic [31:0]       prdata_q, rdata; // read data, mux result
    logic              hit, apb_wr, apb_rd; // mapped, access edge
    // events
    logic [DATA_W-1:0] dec_data; // corrected word
    logic              dec_single, dec_double; // decoder verdicts
    logic              rd_back, take, violate; // read back, taken, refused
    logic              ev_corr, ev_det, ev_opt; // events this cycle

    feoc_secded u_dec
    (
        .i_word   (I_FL_WORD),
        .o_data   (dec_data),
        .o_single (dec_single),
        .o_double (dec_double)
    );

    // event decode for this cycle
    always_comb
    begin
        take    = I_ACC_REQ && ready_q && (state_q == ST_IDLE);
        // refused: debug reads, or writes and erases inside the window
        violate = take && ((I_ACC.op == OP_READ)
                  ? (prot_q[PROT_RDP_BIT] && I_ACC.debug)
                  : (prot_q[PROT_WRP_BIT] && (I_ACC.addr >= wrp_start_q)
                     && (I_ACC.addr <= wrp_end_q)));
        rd_back = (state_q == ST_FLASH) && I_FL_VALID && (acc_q.op == OP_READ);
        ev_corr = rd_back && dec_single;
        ev_det  = rd_back && dec_double;
        ev_opt  = (state_q == ST_LOAD) && I_OPT_VALID && ((I_OPT.value ^ I_OPT.cmpl) != 8'hff);
    end
    // access sequencer; the array must answer, there is no timeout
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            state_q   <= ST_LOAD;
            acc_q     <= '0;
            ready_q   <= 1'b0;
            done_q    <= 1'b0;
            blocked_q <= 1'b0;
            fault_q   <= 1'b0;
            rd_data_q <= '0;
            fl_req_q  <= 1'b0;
            fl_cmd_q  <= '0;
        end
        else if (I_CLK_EN)
        begin
            case (state_q)
                // accesses wait until option bytes are in
                ST_LOAD:
                begin
                    if (I_OPT_VALID && I_OPT.last)
                    begin
                        state_q <= ST_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                ST_IDLE:
                begin
                    if (take)
                    begin
                        acc_q   <= I_ACC;
                        ready_q <= 1'b0;
                        if (violate)
                        begin
                            done_q    <= 1'b1;
                            blocked_q <= 1'b1;
                            fault_q   <= (I_ACC.op == OP_READ);
                            state_q   <= ST_DONE;
                        end
                        else
                        begin
                            fl_req_q <= 1'b1;
                            fl_cmd_q <= I_ACC;
                            state_q  <= ST_FLASH;
                        end
                    end
                end
                ST_FLASH:
                begin
                    fl_req_q <= 1'b0;
                    if (I_FL_VALID)
                    begin
                        done_q  <= 1'b1;
                        state_q <= ST_DONE;
                        // corrected data goes back; a double fault returns raw bits
                        if (acc_q.op == OP_READ)
                            rd_data_q <= dec_data;
                    end
                end
                ST_DONE:
                begin
                    done_q    <= 1'b0;
                    blocked_q <= 1'b0;
                    fault_q   <= 1'b0;
                    ready_q   <= 1'b1;
                    state_q   <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_LOAD;
                    ready_q <= 1'b0;
                end
            endcase
        end
    end
    // option byte verification, held until the next power-on reset
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            opt_err_q  <= 1'b0;
            opt_done_q <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (ev_opt)
                opt_err_q <= 1'b1;
            if ((state_q == ST_LOAD) && I_OPT_VALID && I_OPT.last)
                opt_done_q <= 1'b1;
        end
    end
    // ecc status register; a new event wins over a write-one clear
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ecc_loc_q  <= '0;
            ecc_bank_q <= 1'b0;
            ecc_corr_q <= 1'b0;
            ecc_det_q  <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            if (apb_wr && (I_APB.paddr == OFF_ECC_STAT))
            begin
                if (I_APB.pwdata[ECC_CORR_BIT])
                    ecc_corr_q <= 1'b0;
                if (I_APB.pwdata[ECC_DET_BIT])
                    ecc_det_q <= 1'b0;
            end
            if (ev_corr)
                ecc_corr_q <= 1'b1;
            if (ev_det)
                ecc_det_q <= 1'b1;
            // capture first failure; later ones keep the first location
            if ((ev_corr || ev_det) && !(ecc_corr_q || ecc_det_q))
            begin
                ecc_loc_q  <= acc_q.addr;
                ecc_bank_q <= acc_q.bank;
            end
        end
    end

    // sticky interrupt status, cleared by reading it; set wins
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
            int_stat_q <= '0;
        else if (I_CLK_EN)
            int_stat_q <= {violate, ev_opt, ev_corr}
                | ((apb_rd && (I_APB.paddr == OFF_INT_STAT)) ? '0 : int_stat_q);
    end

    // interrupt lines; one cycle behind the flags they follow
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            irq_q <= 1'b0;
            nmi_q <= 1'b0;
        end
        else if (I_CLK_EN)
        begin
            irq_q <= |(int_stat_q & int_mask_q);
            nmi_q <= ecc_det_q;
        end
    end

    // software-written control registers
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            int_mask_q  <= INT_MASK_RST;
            prot_q      <= PROT_RST;
            wrp_start_q <= WRP_START_RST;
            wrp_end_q   <= WRP_END_RST;
        end
        else if (I_CLK_EN && apb_wr)
        begin
            case (I_APB.paddr)
                OFF_INT_MASK:  int_mask_q  <= I_APB.pwdata[INT_W-1:0];
                OFF_PROT:      prot_q      <= I_APB.pwdata[1:0];
                OFF_WRP_START: wrp_start_q <= I_APB.pwdata[LOC_W-1:0];
                OFF_WRP_END:   wrp_end_q   <= I_APB.pwdata[LOC_W-1:0];
                default:       ;   // read-only or unmapped
            endcase
        end
    end

    // read mux; unaligned or unknown offsets miss
    always_comb
    begin
        rdata = '0;
        hit   = 1'b1;
        case (I_APB.paddr)
            OFF_ECC_STAT:
            begin
                rdata[LOC_W-1:0]    = ecc_loc_q;
                rdata[ECC_BANK_BIT] = ecc_bank_q;
                rdata[ECC_CORR_BIT] = ecc_corr_q;
                rdata[ECC_DET_BIT]  = ecc_det_q;
            end
            OFF_INT_STAT:  rdata[INT_W-1:0] = int_stat_q;
            OFF_INT_MASK:  rdata[INT_W-1:0] = int_mask_q;
            OFF_OPT_STAT:
            begin
                rdata[OPT_ERR_BIT]  = opt_err_q;
                rdata[OPT_DONE_BIT] = opt_done_q;
            end
            OFF_PROT:      rdata[1:0]       = prot_q;
            OFF_WRP_START: rdata[LOC_W-1:0] = wrp_start_q;
            OFF_WRP_END:   rdata[LOC_W-1:0] = wrp_end_q;
            default:       hit              = 1'b0;
        endcase
        apb_wr = I_APB.psel && I_APB.penable && pready_q && I_APB.pwrite && hit;
        apb_rd = I_APB.psel && I_APB.penable && pready_q && !I_APB.pwrite;
    end

    // apb handshake: answer is prepared in setup, so access lasts one cycle
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else if (I_CLK_EN)
        begin
            if (I_APB.psel && !I_APB.penable && !pready_q)
            begin
                pready_q  <= 1'b1;
                pslverr_q <= !hit;
                prdata_q  <= I_APB.pwrite ? 32'h0 : rdata;
            end
            else if (pready_q)
            begin
                pready_q  <= 1'b0;
                pslverr_q <= 1'b0;
            end
        end
    end

    // outputs straight from flip-flops
    assign {O_PRDATA, O_PREADY, O_PSLVERR} = {prdata_q, pready_q, pslverr_q};
    assign {O_ACC_READY, O_ACC_DONE, O_ACC_BLOCKED} = {ready_q, done_q, blocked_q};
    assign {O_FAULT_EXC, O_RD_DATA, O_FL_REQ} = {fault_q, rd_data_q, fl_req_q};
    assign {O_FL_CMD, O_IRQ, O_NMI} = {fl_cmd_q, irq_q, nmi_q};
    assign {O_OPT_VERIFY_ERROR, O_OPT_LOADED} = {opt_err_q, opt_done_q};
endmodule : feoc_top
`default_nettype wire

/* verilog/feoc_pkg.sv */
`default_nettype none
package feoc_pkg;

    // datapath and field widths
    localparam int DATA_W = 64;                // protected double-word
    localparam int CHK_W  = 8;                 // seven hamming bits plus overall parity
    localparam int HAM_W  = 7;                 // hamming syndrome width
    localparam int HAM_N  = 71;                // highest hamming code position
    localparam int LOC_W  = 21;                // double-word location field
    localparam int INT_W  = 3;                 // interrupt status width
    localparam int AW     = 8;                 // apb byte address width

    // register byte offsets
    localparam logic [AW-1:0] OFF_ECC_STAT  = 8'h00;
    localparam logic [AW-1:0] OFF_INT_STAT  = 8'h04;
    localparam logic [AW-1:0] OFF_INT_MASK  = 8'h08;
    localparam logic [AW-1:0] OFF_OPT_STAT  = 8'h0c;
    localparam logic [AW-1:0] OFF_PROT      = 8'h10;
    localparam logic [AW-1:0] OFF_WRP_START = 8'h14;
    localparam logic [AW-1:0] OFF_WRP_END   = 8'h18;

    // field positions
    localparam int ECC_BANK_BIT   = 21;
    localparam int ECC_CORR_BIT   = 30;
    localparam int ECC_DET_BIT    = 31;
    localparam int INT_CORR_BIT   = 0;
    localparam int INT_OPTERR_BIT = 1;
    localparam int INT_PROT_BIT   = 2;
    localparam int OPT_ERR_BIT    = 0;
    localparam int OPT_DONE_BIT   = 1;
    localparam int PROT_RDP_BIT   = 0;
    localparam int PROT_WRP_BIT   = 1;

    // reset values
    localparam logic [INT_W-1:0] INT_MASK_RST  = 3'h0;
    localparam logic [1:0]       PROT_RST      = 2'h0;
    localparam logic [LOC_W-1:0] WRP_START_RST = 21'h0;
    localparam logic [LOC_W-1:0] WRP_END_RST   = 21'h0;

    // access kinds requested by the cpu side
    typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ERASE} feoc_op_e;

    // access sequencer states
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_FLASH, ST_DONE} feoc_state_e;

    // apb request from the master
    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [31:0]   pwdata;
    } feoc_apb_req_s;

    // one flash access: kind, double-word location, bank, debug origin
    typedef struct packed {
        feoc_op_e         op;
        logic [LOC_W-1:0] addr;
        logic             bank;
        logic             debug;
    } feoc_acc_s;

    // raw double-word with its stored check bits
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [CHK_W-1:0]  chk;
    } feoc_fl_word_s;

    // one option byte and its stored complement
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] cmpl;
        logic       last;
    } feoc_opt_s;

    // check bits: data fills non power-of-two positions 3..71 in order,
    // bit i covers positions with bit i set, bit 7 makes total parity even
    function automatic logic [CHK_W-1:0] ecc_encode(input logic [DATA_W-1:0] data);
        logic [CHK_W-1:0] chk;
        int               k;
        chk = '0;
        k   = 0;
        for (int p = 1; p <= HAM_N; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                for (int i = 0; i < HAM_W; i++)
                begin
                    if (p[i])
                        chk[i] = chk[i] ^ data[k];
                end
                k++;
            end
        end
        chk[CHK_W-1] = ^{data, chk[HAM_W-1:0]};
        return chk;
    endfunction : ecc_encode

endpackage : feoc_pkg
`default_nettype wire

/* verilog/feoc_secded.sv */
`default_nettype none
// single-error-correct, double-error-detect decoder, purely combinational
module feoc_secded
(
    input  wire  feoc_pkg::feoc_fl_word_s      i_word,   // raw word and check bits
    output logic [feoc_pkg::DATA_W-1:0]        o_data,   // corrected data
    output logic                               o_single, // one bit fixed
    output logic                               o_double  // uncorrectable
);
    import feoc_pkg::*;

    // rebuild codeword, syndrome, then repair one position
    always_comb
    begin
        logic [HAM_N:0]   cw;
        logic [HAM_W-1:0] syn;
        logic             par;
        int               k;
        int               j;
        cw  = '0;
        syn = '0;
        k   = 0;
        j   = 0;
        cw[0] = i_word.chk[CHK_W-1];
        for (int p = 1; p <= HAM_N; p++)
        begin
            // power-of-two slots carry the hamming bits
            if ((p & (p - 1)) == 0)
            begin
                cw[p] = i_word.chk[j];
                j++;
            end
            else
            begin
                cw[p] = i_word.data[k];
                k++;
            end
        end
        for (int p = 1; p <= HAM_N; p++)
        begin
            if (cw[p])
                syn = syn ^ p[HAM_W-1:0];
        end
        par      = ^cw;
        o_single = 1'b0;
        o_double = 1'b0;
        // odd parity with a syndrome beyond the word is a multi-bit fault
        if (par && (int'(syn) > HAM_N))
            o_double = 1'b1;
        else if (par)
        begin
            o_single = 1'b1;
            cw[syn]  = ~cw[syn];
        end
        else if (syn != '0)
            o_double = 1'b1;
        o_data = '0;
        k      = 0;
        for (int p = 1; p <= HAM_N; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                o_data[k] = cw[p];
                k++;
            end
        end
    end

endmodule : feoc_secded
`default_nettype wire

/* sim/feoc_assertions.sv */
`default_nettype none
// port-level checks on the top module, bound in from the bench
module feoc_assertions
(
    input  wire logic                 I_CLK_SYS,
    input  wire logic                 I_RST_N,
    input  wire logic                 I_OPT_VALID,
    input  wire feoc_pkg::feoc_opt_s  I_OPT,
    input  wire logic                 I_ACC_REQ,
    input  wire logic                 O_ACC_READY,
    input  wire logic                 O_ACC_DONE,
    input  wire logic                 O_ACC_BLOCKED,
    input  wire logic                 O_FAULT_EXC,
    input  wire logic                 O_FL_REQ,
    input  wire logic                 I_FL_VALID,
    input  wire logic                 O_OPT_VERIFY_ERROR,
    input  wire logic                 O_OPT_LOADED
);
    import feoc_pkg::*;
    // one clock domain, so a single default
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    property p_opt_bad; I_OPT_VALID && !O_OPT_LOADED && (I_OPT.value ^ I_OPT.cmpl) != 8'hff
        |=> O_OPT_VERIFY_ERROR; endproperty
    a_opt_bad: assert property (p_opt_bad) else $error("mismatch not flagged");
    property p_opt_good; I_OPT_VALID && !O_OPT_LOADED && (I_OPT.value ^ I_OPT.cmpl) == 8'hff
        && !O_OPT_VERIFY_ERROR |=> !O_OPT_VERIFY_ERROR; endproperty
    a_opt_good: assert property (p_opt_good) else $error("false mismatch");
    property p_opt_hold; O_OPT_VERIFY_ERROR |=> O_OPT_VERIFY_ERROR; endproperty
    a_opt_hold: assert property (p_opt_hold) else $error("option error lost");
    property p_gate; !O_OPT_LOADED |-> !O_ACC_READY; endproperty
    a_gate: assert property (p_gate) else $error("access before load");
    property p_check; I_FL_VALID |=> O_ACC_DONE && !O_ACC_BLOCKED; endproperty
    a_check: assert property (p_check) else $error("read not completed");
    property p_take; I_ACC_REQ && O_ACC_READY |=> O_FL_REQ || O_ACC_BLOCKED; endproperty
    a_take: assert property (p_take) else $error("request not served");
    property p_blk; O_ACC_BLOCKED |-> O_ACC_DONE && !O_FL_REQ; endproperty
    a_blk: assert property (p_blk) else $error("blocked access reached array");
    property p_fault; O_FAULT_EXC |-> O_ACC_BLOCKED; endproperty
    a_fault: assert property (p_fault) else $error("fault without block");
    property p_done; O_ACC_DONE |=> !O_ACC_DONE && O_ACC_READY; endproperty
    a_done: assert property (p_done) else $error("done pulse wrong");
endmodule : feoc_assertions
`default_nettype wire

/* sim/feoc_flash_model.sv */
`default_nettype none
// flash array: answers every request once, after one or four cycles
module feoc_flash_model
(
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_n,
    input  wire logic                    i_req,
    input  wire feoc_pkg::feoc_acc_s     i_cmd,
    input  wire logic                    i_slow,  // slow answer
    input  wire logic [71:0]             i_flip,  // injected bit faults
    output feoc_pkg::feoc_fl_word_s      o_word,
    output logic                         o_valid
);
    import feoc_pkg::*;
    logic [2:0]       wait_q; // cycles to answer, 0 idle
    logic [LOC_W-1:0] addr_q; // latched location
    logic [63:0]      dat;    // stored contents
    function automatic logic [7:0] enc(input logic [63:0] d);
        logic [7:0] c;
        int         k;
        c = '0;
        k = 0;
        for (int p = 1; p <= 71; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                c[6:0] = c[6:0] ^ ({7{d[k]}} & p[6:0]);
                k++;
            end
        end
        c[7] = ^{d, c[6:0]};
        return c;
    endfunction : enc
    assign dat = {2{11'h2a5, addr_q}};
    // idle word toggles so stale data is never reused
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_q  <= '0;
            addr_q  <= '0;
            o_valid <= 1'b0;
            o_word  <= '0;
        end
        else if (i_req)
        begin
            wait_q  <= i_slow ? 3'h4 : 3'h1;
            addr_q  <= i_cmd.addr;
            o_valid <= 1'b0;
            o_word  <= ~o_word;
        end
        else
        begin
            wait_q  <= (wait_q != 3'h0) ? wait_q - 3'h1 : 3'h0;
            o_valid <= wait_q == 3'h1;
            o_word  <= (wait_q == 3'h1) ? ({dat, enc(dat)} ^ i_flip) : ~o_word;
        end
    end
endmodule : feoc_flash_model
`default_nettype wire

/* sim/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import feoc_pkg::*;
    logic          clk, rst_n, opt_v, acc_req, fl_v, slow, e;
    logic          pready, pslverr, rdy, done, blk, fexc, fl_req, irq, nmi, operr, oload;
    feoc_apb_req_s apb;
    feoc_opt_s     opt;
    feoc_acc_s     acc, fl_cmd;
    feoc_fl_word_s fl_word;
    logic [71:0]   flip;
    logic [31:0]   prdata, r;
    logic [63:0]   rd;
    int            mismatches, tests_run;
    feoc_top dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CLK_EN(1'b1), .I_APB(apb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OPT_VALID(opt_v),
        .I_OPT(opt), .I_ACC_REQ(acc_req), .I_ACC(acc), .O_ACC_READY(rdy), .O_ACC_DONE(done),
        .O_ACC_BLOCKED(blk), .O_FAULT_EXC(fexc), .O_RD_DATA(rd), .O_FL_REQ(fl_req),
        .O_FL_CMD(fl_cmd), .I_FL_VALID(fl_v), .I_FL_WORD(fl_word), .O_IRQ(irq), .O_NMI(nmi),
        .O_OPT_VERIFY_ERROR(operr), .O_OPT_LOADED(oload));
    feoc_flash_model u_fl (.i_clk(clk), .i_rst_n(rst_n), .i_req(fl_req), .i_cmd(fl_cmd),
        .i_slow(slow), .i_flip(flip), .o_word(fl_word), .o_valid(fl_v));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [63:0] dw(input logic [20:0] a);
        return {2{11'h2a5, a}};
    endfunction : dw
    task check(input string n, input logic [71:0] x, input logic [71:0] g);
        tests_run++;
        if (g !== x)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : check
    task stop_test;
        if (mismatches == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // apb cycle: setup, then access held until pready
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb.penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        apb <= '0;
    endtask : bus
    task rchk(input string n, input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0);
        check(n, x, r);
    endtask : rchk
    // one access, returns once done is seen
    task access(input feoc_op_e op, input logic [20:0] a, input logic dbg);
        while (rdy !== 1'b1)
            @(posedge clk);
        acc_req <= 1'b1;
        acc <= '{op, a, 1'b1, dbg};
        do
        begin
            @(posedge clk);
            acc_req <= 1'b0;
            #1;
        end
        while (done !== 1'b1);
    endtask : access
    task t_reset;
        rchk("ecc_stat", OFF_ECC_STAT, 32'h0);
        rchk("int_mask", OFF_INT_MASK, 32'h0);
        rchk("prot", OFF_PROT, 32'h0);
        rchk("wrp_end", OFF_WRP_END, 32'h0);
        rchk("unmapped", 8'h1c, 32'h0);
        check("slverr", 1, e);
        check("ready_early", 0, rdy);
    endtask : t_reset
    task t_opt;
        bus(1'b1, OFF_INT_MASK, 32'h7);
        opt_v <= 1'b1;
        opt <= '{8'h3c, 8'hc3, 1'b0};
        @(posedge clk);
        opt <= '{8'h55, 8'hab, 1'b0};
        @(posedge clk);
        opt <= '{8'h0f, 8'hf0, 1'b1};
        @(posedge clk);
        opt_v <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("opt_err", 3, {operr, oload});
        check("irq_opt", 1, irq);
        bus(1'b1, OFF_OPT_STAT, 32'h0);
        rchk("opt_stat", OFF_OPT_STAT, 32'h3);
        rchk("int_stat", OFF_INT_STAT, 32'h2);
        rchk("int_clr", OFF_INT_STAT, 32'h0);
    endtask : t_opt
    task t_ecc;
        access(OP_READ, 21'h5, 1'b0);
        check("clean", dw(21'h5), rd);
        rchk("stat0", OFF_ECC_STAT, 32'h0);
        flip <= 72'h1 << 17;
        slow <= 1'b1;
        access(OP_READ, 21'h1a5a5, 1'b0);
        check("fixed", dw(21'h1a5a5), rd);
        repeat (2) @(posedge clk);
        #1;
        check("irq", 1, irq);
        rchk("corr", OFF_ECC_STAT, 32'h4021a5a5);
        flip <= 72'h1;
        slow <= 1'b0;
        access(OP_READ, 21'h7, 1'b0);
        rchk("kept", OFF_ECC_STAT, 32'h4021a5a5);
        rchk("int_ecc", OFF_INT_STAT, 32'h1);
        bus(1'b1, OFF_ECC_STAT, 32'hc0000000);
        flip <= 72'h3 << 30;
        access(OP_READ, 21'h9, 1'b0);
        check("raw", dw(21'h9) ^ (64'h3 << 22), rd);
        check("dbl_blk", 0, blk);
        rchk("det", OFF_ECC_STAT, 32'h80200009);
        check("nmi", 1, nmi);
        bus(1'b1, OFF_ECC_STAT, 32'hc0000000);
        repeat (2) @(posedge clk);
        #1;
        check("nmi_clr", 0, nmi);
        flip <= '0;
    endtask : t_ecc
    task t_prot;
        logic [20:0] ad [4];
        ad = '{21'ha, 21'h14, 21'h9, 21'h15};
        bus(1'b1, OFF_PROT, 32'h1);
        access(OP_READ, 21'h3, 1'b1);
        check("rdp", 3, {blk, fexc});
        access(OP_READ, 21'h3, 1'b0);
        check("rdp_ok", dw(21'h3), rd);
        bus(1'b1, OFF_PROT, 32'h2);
        bus(1'b1, OFF_WRP_START, 32'ha);
        bus(1'b1, OFF_WRP_END, 32'h14);
        for (int i = 0; i < 4; i++)
        begin
            access(i[0] ? OP_ERASE : OP_WRITE, ad[i], 1'b0);
            check("wrp", {i < 2, 1'b0}, {blk, fexc});
        end
        rchk("int_prot", OFF_INT_STAT, 32'h4);
    endtask : t_prot
    initial
    begin
        {rst_n, opt_v, acc_req, slow} = '0;
        apb = '0;
        opt = '0;
        acc = '0;
        flip = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_opt();
        t_ecc();
        t_prot();
        stop_test();
    end
    // hang guard
    initial
    begin
        #100us;
        mismatches++;
        stop_test();
    end
endmodule : tb
bind feoc_top feoc_assertions u_chk (.I_CLK_SYS, .I_RST_N, .I_OPT_VALID, .I_OPT, .I_ACC_REQ,
    .O_ACC_READY, .O_ACC_DONE, .O_ACC_BLOCKED, .O_FAULT_EXC, .O_FL_REQ, .I_FL_VALID,
    .O_OPT_VERIFY_ERROR, .O_OPT_LOADED);
`default_nettype wire
